// [core/cmt_params.svh]
// Constants of the channel timing and counter block: offsets, fields, resets, timing
`ifndef CMT_PARAMS_SVH
`define CMT_PARAMS_SVH

// APB register byte offsets
`define CMT_OFF_CTRL 12'h000
`define CMT_OFF_STATUS 12'h004
`define CMT_OFF_COUNT 12'h008
`define CMT_OFF_ADDR 12'h00C

// Control register fields and reset value
`define CMT_CTRL_OUTPUT_BIT 0
`define CMT_CTRL_REVERSE_BIT 1
`define CMT_CTRL_RESET 2'h0

// Status register field positions
`define CMT_ST_DEVADDR_LSB 0
`define CMT_ST_MATCH_BIT 8
`define CMT_ST_PENDING_BIT 9
`define CMT_ST_MEM_READY_BIT 10
`define CMT_ST_BUF_READY_BIT 11
`define CMT_ST_REFUSED_BIT 12

// Datapath reset values
`define CMT_DEVADDR_RESET 8'h00
`define CMT_COUNT_RESET 16'h0000
`define CMT_ADDR_RESET 19'h00000

// Location that holds the device address for instructions
`define CMT_INSTR_LOCATION 19'h00020

// Clock period and delay-line figures in ns
`define CMT_CLK_NS 10
`define CMT_MEM_WIDTH_NS 80
`define CMT_MEM_LATE_NS 280
`define CMT_MEM_LEN_NS 380
`define CMT_BUF_WIDTH_NS 40
`define CMT_BUF_LEN_NS 40
`define CMT_TAP_MID_NS 120
`define CMT_TAP_LATE2_NS 160

// Cycle counts derived from the figures (all are exact multiples of the period)
`define CMT_CYC(ns) (((ns) + `CMT_CLK_NS - 1) / `CMT_CLK_NS)

`endif

// [core/cmt_pkg.sv]
// Types of the channel timing and counter block
package cmt_pkg;

  // Kind of memory phase being sequenced
  typedef enum logic [1:0] {
    CMT_PH_INSTR,
    CMT_PH_CMD_EVEN,
    CMT_PH_CMD_ODD,
    CMT_PH_DATA
  } cmt_phase_t;

  // Memory phase sequencer states
  typedef enum logic [2:0] {
    CMT_MS_IDLE,
    CMT_MS_FIRST,
    CMT_MS_WAIT_B,
    CMT_MS_SECOND,
    CMT_MS_DRAIN
  } cmt_mstate_t;

  // Four timing taps of one group
  typedef struct packed {
    logic t0;
    logic t80;
    logic t120;
    logic t280;
  } cmt_taps_t;

  // APB request carried as one bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } cmt_apb_req_t;

endpackage

// [core/cmt_delay_line.sv]
// Cycle-counted model of a tapped delay line with a ready latch and two runs in flight
`timescale 1ns/1ns
`default_nettype none
module cmt_delay_line #(
  parameter logic [8:0] W_CYC = 9'd8,
  parameter logic [8:0] REARM_CYC = 9'd28,
  parameter logic [8:0] LEN_CYC = 9'd38
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic request,
  output logic start,
  output logic trigger,
  output var logic ready_r,
  output var logic [1:0] act_r,
  output var logic [8:0] age0_r,
  output var logic [8:0] age1_r,
  output var logic slot_r
);
  logic newest;
  logic [8:0] new_age;

  // A request launches a run only while the ready latch is set
  assign start = request & ready_r;
  assign newest = ~slot_r;
  assign new_age = newest ? age1_r : age0_r;
  // Input pulse of the line lasts the width tap of the newest run
  assign trigger = act_r[newest] & (new_age < W_CYC);

  // Ready latch: cleared by a launch, set again at the rearm tap
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_r <= 1'b1;
      slot_r <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        ready_r <= 1'b0;
        slot_r <= ~slot_r;
      end else if (act_r[newest] && new_age == REARM_CYC - 9'd1) begin
        ready_r <= 1'b1;
      end
    end
  end

  // Run slot 0: ages until the line end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_r[0] <= 1'b0;
      age0_r <= 9'h000;
    end else if (clk_en) begin
      if (start && !slot_r) begin
        act_r[0] <= 1'b1;
        age0_r <= 9'h000;
      end else if (act_r[0]) begin
        act_r[0] <= (age0_r != LEN_CYC - 9'd1);
        age0_r <= age0_r + 9'd1;
      end
    end
  end

  // Run slot 1: second pulse that may overlap the first
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_r[1] <= 1'b0;
      age1_r <= 9'h000;
    end else if (clk_en) begin
      if (start && slot_r) begin
        act_r[1] <= 1'b1;
        age1_r <= 9'h000;
      end else if (act_r[1]) begin
        act_r[1] <= (age1_r != LEN_CYC - 9'd1);
        age1_r <= age1_r + 9'd1;
      end
    end
  end
endmodule
`default_nettype wire

// [core/cmt_channel.sv]
// Memory phase timing, buffer timing and address/count datapath of a selector channel
//
// Behaviour
// - Memory phases each held by a first-rank latch, then a second-rank latch.
// - Memory timer runs twice per phase: at first-rank set and second-rank set.
// - Timer ready latch set by reset or late tap; requests trigger only when set.
// - Second-rank trigger accepted only after the first-rank trigger in that phase.
// - Ready latch clears on a launch; input pulse and taps are each 80 ns wide.
// - Second run waits for 280 ns of the first; both runs may overlap.
// - Timing taps split into groups qualified by first-rank or second-rank.
// - Buffer timer starts on read or write request with ready set; 40 ns pulse.
// - Buffer read/write priority resolved only after the buffer timer started.
// - Output transfers favour writes, input transfers favour reads.
// - 8-bit device address loaded on a successful start instruction.
// - Halt compares device address with I/O byte A; equality flags a match.
// - Acknowledge clears interrupt status by address; start refused while pending.
// - Device address kept until next successful start; nothing else clears it.
// - 16-bit byte count loaded from second command word, stepped down per byte.
// - Instruction response places byte count into memory assembly bytes C and D.
// - Count state and low address bits form byte presence, selecting step 0-4.
// - 19-bit byte address loaded from the first command word.
// - Byte address counts up for forward orders, down for reverse reads.
// - Low two address bits copied on forward loads, inverted on reverse reads.
`timescale 1ns/1ns
`default_nettype none
`include "cmt_params.svh"
module cmt_channel (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire cmt_pkg::cmt_apb_req_t apb_req,
  output logic pready,
  output var logic [31:0] prdata,
  output logic pslverr,
  input wire logic mem_phase_req,
  input wire cmt_pkg::cmt_phase_t mem_phase_kind,
  output var logic phase_first_rank,
  output var logic phase_second_rank,
  output var logic mem_phase_done,
  output logic memory_timer_trigger,
  output logic memory_timer_ready,
  output var cmt_pkg::cmt_taps_t group_a_taps,
  output var cmt_pkg::cmt_taps_t group_b_taps,
  input wire logic buffer_read_request,
  input wire logic buffer_write_request,
  output logic buffer_timer_trigger,
  output var logic buffer_read_phase,
  output var logic buffer_write_phase,
  input wire logic [31:0] mem_data,
  input wire logic [31:0] io_register,
  input wire logic start_io_instruction,
  input wire logic halt_io_instruction,
  input wire logic acknowledge_io_instruction,
  input wire logic device_interrupt,
  input wire logic count_load_strobe,
  input wire logic byte_pointer_load_strobe,
  input wire logic presence_strobe,
  input wire logic count_step_strobe,
  input wire logic respond_strobe,
  output var logic [7:0] device_address,
  output var logic address_match,
  output var logic start_refused,
  output var logic interrupt_pending,
  output var logic [15:0] byte_count,
  output var logic [18:0] byte_pointer,
  output var logic [3:0] byte_presence,
  output var logic [31:0] response_word
);
  // Cycle counts at the system clock
  localparam logic [8:0] MEM_W = 9'(`CMT_CYC(`CMT_MEM_WIDTH_NS));
  localparam logic [8:0] MEM_LATE = 9'(`CMT_CYC(`CMT_MEM_LATE_NS));
  localparam logic [8:0] MEM_LEN = 9'(`CMT_CYC(`CMT_MEM_LEN_NS));
  localparam logic [8:0] BUF_W = 9'(`CMT_CYC(`CMT_BUF_WIDTH_NS));
  localparam logic [8:0] BUF_LEN = 9'(`CMT_CYC(`CMT_BUF_LEN_NS));
  localparam logic [8:0] TAP_MID = 9'(`CMT_CYC(`CMT_TAP_MID_NS));

  // Tap is high for one pulse width after its delay
  function automatic logic tap_on(input logic act, input logic [8:0] age,
                                  input logic [8:0] dly, input logic [8:0] wid);
    tap_on = act && (age >= dly) && (age < dly + wid);
  endfunction

  // Bytes still in the current word, limited by the remaining count
  function automatic logic [3:0] presence_of(input logic [15:0] cnt, input logic [1:0] lane);
    logic [2:0] room;
    room = 3'd4 - {1'b0, lane};
    if (cnt == 16'h0000) begin
      presence_of = 4'h0;
    end else if (cnt < {13'h0000, room}) begin
      presence_of = 4'(4'hF >> (3'd4 - cnt[2:0]));
    end else begin
      presence_of = 4'(4'hF >> (3'd4 - room));
    end
  endfunction

  // Number of set presence bits gives the step
  function automatic logic [2:0] step_of(input logic [3:0] pres);
    step_of = 3'(pres[0]) + 3'(pres[1]) + 3'(pres[2]) + 3'(pres[3]);
  endfunction

  // ---------------- Register bus ----------------
  logic [1:0] ctrl_r;
  logic output_mode;
  logic reverse_direction;
  logic forward_direction;
  logic apb_access;
  logic apb_wr;
  logic hit_ctrl;
  logic hit_status;
  logic hit_count;
  logic hit_addr;
  logic apb_hit;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic buffer_ready_w;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign apb_access = apb_req.psel & apb_req.penable;
  assign apb_wr = apb_access & apb_req.pwrite;
  assign hit_ctrl = (apb_req.paddr == `CMT_OFF_CTRL);
  assign hit_status = (apb_req.paddr == `CMT_OFF_STATUS);
  assign hit_count = (apb_req.paddr == `CMT_OFF_COUNT);
  assign hit_addr = (apb_req.paddr == `CMT_OFF_ADDR);
  assign apb_hit = hit_ctrl | hit_status | hit_count | hit_addr;
  assign pslverr = apb_access & ~apb_hit;
  assign output_mode = ctrl_r[`CMT_CTRL_OUTPUT_BIT];
  assign reverse_direction = ctrl_r[`CMT_CTRL_REVERSE_BIT];
  assign forward_direction = ~reverse_direction;

  // Status word gathers live block state
  assign status_word = {19'h00000, start_refused, buffer_ready_w, memory_timer_ready,
                        interrupt_pending, address_match, device_address};
  assign rd_mux = hit_ctrl ? {30'h00000000, ctrl_r} :
                  hit_status ? status_word :
                  hit_count ? {16'h0000, byte_count} :
                  hit_addr ? {13'h0000, byte_pointer} : 32'h00000000;

  // Control register: only byte lane 0 is writable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `CMT_CTRL_RESET;
    end else if (clk_en && apb_wr && hit_ctrl && apb_req.pstrb[0]) begin
      ctrl_r <= apb_req.pwdata[1:0];
    end
  end

  // Read data registered in the setup cycle so it is stable in the access cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (clk_en && apb_req.psel && !apb_req.penable) begin
      prdata <= rd_mux;
    end
  end

  // ---------------- Memory timing generator ----------------
  logic mem_start;
  logic [1:0] mem_act;
  logic [8:0] mem_age0;
  logic [8:0] mem_age1;
  logic mem_slot;
  logic request_first;
  logic request_second;
  logic [1:0] run_rank_r;
  logic first_fired_r;
  logic second_fired_r;
  cmt_pkg::cmt_mstate_t mstate_r;
  cmt_pkg::cmt_phase_t phase_kind_r;

  // Ready latch re-arms at 280 ns, input pulse is 80 ns wide
  cmt_delay_line #(.W_CYC(MEM_W), .REARM_CYC(MEM_LATE), .LEN_CYC(MEM_LEN)) u_mem_line (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .request(request_first | request_second),
    .start(mem_start),
    .trigger(memory_timer_trigger),
    .ready_r(memory_timer_ready),
    .act_r(mem_act),
    .age0_r(mem_age0),
    .age1_r(mem_age1),
    .slot_r(mem_slot)
  );

  // Second request only once the first run of this phase has launched
  assign request_first = phase_first_rank & ~first_fired_r;
  assign request_second = phase_second_rank & first_fired_r & ~second_fired_r;

  // Phase sequencer: first rank, wait for re-arm, second rank, wait again
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mstate_r <= cmt_pkg::CMT_MS_IDLE;
      phase_kind_r <= cmt_pkg::CMT_PH_INSTR;
      phase_first_rank <= 1'b0;
      phase_second_rank <= 1'b0;
      first_fired_r <= 1'b0;
      second_fired_r <= 1'b0;
      mem_phase_done <= 1'b0;
    end else if (clk_en) begin
      mem_phase_done <= 1'b0;
      case (mstate_r)
        cmt_pkg::CMT_MS_IDLE: begin
          if (mem_phase_req) begin
            phase_kind_r <= mem_phase_kind;
            phase_first_rank <= 1'b1;
            mstate_r <= cmt_pkg::CMT_MS_FIRST;
          end
        end
        cmt_pkg::CMT_MS_FIRST: begin
          if (mem_start) begin
            first_fired_r <= 1'b1;
            mstate_r <= cmt_pkg::CMT_MS_WAIT_B;
          end
        end
        cmt_pkg::CMT_MS_WAIT_B: begin
          // Second rank follows the first, once the line can take a new run
          if (memory_timer_ready) begin
            phase_second_rank <= 1'b1;
            mstate_r <= cmt_pkg::CMT_MS_SECOND;
          end
        end
        cmt_pkg::CMT_MS_SECOND: begin
          if (mem_start) begin
            second_fired_r <= 1'b1;
            mstate_r <= cmt_pkg::CMT_MS_DRAIN;
          end
        end
        cmt_pkg::CMT_MS_DRAIN: begin
          // Phase ends when the second run reaches its late tap
          if (memory_timer_ready) begin
            phase_first_rank <= 1'b0;
            phase_second_rank <= 1'b0;
            first_fired_r <= 1'b0;
            second_fired_r <= 1'b0;
            mem_phase_done <= 1'b1;
            mstate_r <= cmt_pkg::CMT_MS_IDLE;
          end
        end
        default: mstate_r <= cmt_pkg::CMT_MS_IDLE;
      endcase
    end
  end

  // Each run remembers which rank launched it, so overlapping runs stay apart
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_rank_r <= 2'b00;
    end else if (clk_en && mem_start) begin
      run_rank_r[mem_slot] <= request_second;
    end
  end

  // Tap groups: A for first-rank runs, B for second-rank runs
  cmt_pkg::cmt_taps_t taps0;
  cmt_pkg::cmt_taps_t taps1;
  assign taps0 = {tap_on(mem_act[0], mem_age0, 9'd0, MEM_W), tap_on(mem_act[0], mem_age0, MEM_W, MEM_W),
                  tap_on(mem_act[0], mem_age0, TAP_MID, MEM_W),
                  tap_on(mem_act[0], mem_age0, MEM_LATE, MEM_W)};
  assign taps1 = {tap_on(mem_act[1], mem_age1, 9'd0, MEM_W), tap_on(mem_act[1], mem_age1, MEM_W, MEM_W),
                  tap_on(mem_act[1], mem_age1, TAP_MID, MEM_W),
                  tap_on(mem_act[1], mem_age1, MEM_LATE, MEM_W)};

  // Tap outputs registered, one cycle behind the line position
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      group_a_taps <= '0;
      group_b_taps <= '0;
    end else if (clk_en) begin
      group_a_taps <= (run_rank_r[0] ? 4'h0 : taps0) | (run_rank_r[1] ? 4'h0 : taps1);
      group_b_taps <= (run_rank_r[0] ? taps0 : 4'h0) | (run_rank_r[1] ? taps1 : 4'h0);
    end
  end

  // ---------------- Buffer timing and arbitration ----------------
  logic buf_start;
  logic [1:0] buf_act;
  logic buf_decide_r;

  // Buffer line: 40 ns pulse, re-armed at its own end
  cmt_delay_line #(.W_CYC(BUF_W), .REARM_CYC(BUF_W), .LEN_CYC(BUF_LEN)) u_buf_line (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .request(buffer_read_request | buffer_write_request),
    .start(buf_start),
    .trigger(buffer_timer_trigger),
    .ready_r(buffer_ready_w),
    .act_r(buf_act),
    .age0_r(),
    .age1_r(),
    .slot_r()
  );

  // Priority sampled one cycle after launch, so a late request still wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_decide_r <= 1'b0;
      buffer_read_phase <= 1'b0;
      buffer_write_phase <= 1'b0;
    end else if (clk_en) begin
      buf_decide_r <= buf_start;
      if (buf_decide_r) begin
        // Output keeps the buffer full, input keeps it empty
        buffer_write_phase <= buffer_write_request & (output_mode | ~buffer_read_request);
        buffer_read_phase <= buffer_read_request & (~output_mode | ~buffer_write_request);
      end else if (buf_act == 2'b00) begin
        buffer_read_phase <= 1'b0;
        buffer_write_phase <= 1'b0;
      end
    end
  end

  // ---------------- Device address and interrupt status ----------------
  logic start_ok;
  logic ack_hit;

  // Start is refused while an interrupt is still unacknowledged
  assign start_ok = start_io_instruction & ~interrupt_pending;
  assign ack_hit = acknowledge_io_instruction & (io_register[31:24] == device_address);

  // Address register changes only on a successful start
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      device_address <= `CMT_DEVADDR_RESET;
    end else if (clk_en && start_ok) begin
      device_address <= io_register[31:24];
    end
  end

  // Match, refusal and interrupt status; a new interrupt beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      address_match <= 1'b0;
      start_refused <= 1'b0;
      interrupt_pending <= 1'b0;
    end else if (clk_en) begin
      if (halt_io_instruction) begin
        address_match <= (io_register[31:24] == device_address);
      end
      if (start_io_instruction) begin
        start_refused <= interrupt_pending;
      end
      if (device_interrupt) begin
        interrupt_pending <= 1'b1;
      end else if (ack_hit) begin
        interrupt_pending <= 1'b0;
      end
    end
  end

  // ---------------- Byte count and byte address ----------------
  logic [2:0] step;
  logic [1:0] load_lane;

  assign step = step_of(byte_presence);
  // Reverse reads store the lane bits inverted
  assign load_lane = reverse_direction ? ~mem_data[1:0] : mem_data[1:0];

  // Presence captured at data service from count and lane bits
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_presence <= 4'h0;
    end else if (clk_en && presence_strobe) begin
      byte_presence <= presence_of(byte_count, byte_pointer[1:0]);
    end
  end

  // Count loads from the second command word and steps down
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_count <= `CMT_COUNT_RESET;
    end else if (clk_en) begin
      if (count_load_strobe) begin
        byte_count <= mem_data[15:0];
      end else if (count_step_strobe) begin
        byte_count <= byte_count - {13'h0000, step};
      end
    end
  end

  // Address loads from the first command word; direction picks up or down
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_pointer <= `CMT_ADDR_RESET;
    end else if (clk_en) begin
      if (byte_pointer_load_strobe) begin
        byte_pointer <= {mem_data[18:2], load_lane};
      end else if (count_step_strobe && forward_direction) begin
        byte_pointer <= byte_pointer + {16'h0000, step};
      end else if (count_step_strobe) begin
        byte_pointer <= byte_pointer - {16'h0000, step};
      end
    end
  end

  // Instruction response: count in bytes C and D
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      response_word <= 32'h00000000;
    end else if (clk_en && respond_strobe) begin
      response_word <= {16'h0000, byte_count};
    end
  end
endmodule
`default_nettype wire

// [tb/cmt_channel_chk.sv]
// Concurrent checks on the ports of the channel timing and counter block
`timescale 1ns/1ns
`default_nettype none
module cmt_channel_chk (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic phase_first_rank,
  input wire logic phase_second_rank,
  input wire logic memory_timer_trigger,
  input wire cmt_pkg::cmt_taps_t group_a_taps,
  input wire cmt_pkg::cmt_taps_t group_b_taps,
  input wire logic buffer_timer_trigger,
  input wire logic buffer_read_phase,
  input wire logic buffer_write_phase,
  input wire logic [31:0] io_register,
  input wire logic start_io_instruction,
  input wire logic halt_io_instruction,
  input wire logic count_load_strobe,
  input wire logic count_step_strobe,
  input wire logic interrupt_pending,
  input wire logic start_refused,
  input wire logic [7:0] device_address,
  input wire logic address_match,
  input wire logic [15:0] byte_count,
  input wire logic [3:0] byte_presence
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [5:0] gap_r;
  // Cycles since the last launch; saturating keeps a long idle from wrapping
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) gap_r <= 6'h3F;
    else if ($rose(memory_timer_trigger)) gap_r <= 6'h00;
    else if (gap_r != 6'h3F) gap_r <= gap_r + 6'h01;
  end
  sequence mem_run;
    memory_timer_trigger[*8] ##1 !memory_timer_trigger;
  endsequence
  sequence buf_run;
    buffer_timer_trigger[*4] ##1 !buffer_timer_trigger;
  endsequence
  rank_order_a: assert property (phase_second_rank |-> phase_first_rank)
    else $error("second rank set without first rank");
  mem_width_a: assert property ($rose(memory_timer_trigger) |-> mem_run)
    else $error("memory line pulse not 8 cycles");
  mem_gap_a: assert property ($rose(memory_timer_trigger) |-> gap_r >= 6'h1B)
    else $error("memory line relaunched too early");
  group_a_a: assert property ($rose(group_a_taps.t0) |-> phase_first_rank && !phase_second_rank)
    else $error("group a tap outside first rank");
  group_b_a: assert property ($rose(group_b_taps.t0) |-> phase_second_rank)
    else $error("group b tap outside second rank");
  buf_width_a: assert property ($rose(buffer_timer_trigger) |-> buf_run)
    else $error("buffer line pulse not 4 cycles");
  buf_excl_a: assert property (buffer_read_phase |-> !buffer_write_phase)
    else $error("buffer read and write both granted");
  halt_match_a: assert property (halt_io_instruction |=>
    address_match == ($past(device_address) == $past(io_register[31:24])))
    else $error("address match wrong after halt");
  start_refuse_a: assert property (start_io_instruction && interrupt_pending |=>
    start_refused && $stable(device_address))
    else $error("start accepted while interrupt pending");
  addr_hold_a: assert property (!$past(start_io_instruction) |-> $stable(device_address))
    else $error("device address changed without start");
  count_step_a: assert property (count_step_strobe && !count_load_strobe |=>
    byte_count == $past(byte_count) - 16'($countones($past(byte_presence))))
    else $error("byte count step wrong");
endmodule
bind cmt_channel cmt_channel_chk chk (.*);
`default_nettype wire

// [tb/cmt_mem_partner.sv]
// Core memory stand-in: raises phase requests and serves command words
`timescale 1ns/1ns
`default_nettype none
module cmt_mem_partner (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic sel,
  input wire logic phase_first_rank,
  output var logic mem_phase_req,
  output logic [31:0] mem_data
);
  // Request held until the first rank shows the phase was taken
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) mem_phase_req <= 1'b0;
    else if (go) mem_phase_req <= 1'b1;
    else if (phase_first_rank) mem_phase_req <= 1'b0;
  end
  // Word served with sel low carries the count, word with sel high the byte address
  assign mem_data = sel ? 32'h00002006 : 32'h00010007;
endmodule
`default_nettype wire

// [tb/tb_cmt_channel.sv]
// Self-checking bench for the channel timing and counter block
`timescale 1ns/1ns
`default_nettype none
module tb_cmt_channel;
  logic sys_clk, reset_n, go, sel, rd, wr, trig_q, mreq, rdy, pslv, done, trig;
  cmt_pkg::cmt_apb_req_t req;
  logic [31:0] io, mdat, q, prd, resp;
  logic [8:0] st;
  logic [7:0] dva;
  logic [15:0] cnt;
  logic [18:0] bp;
  logic [3:0] pres;
  logic match, refd, wph, rph;
  int bad_count, total_checks, rises;
  cmt_mem_partner mem (.sys_clk(sys_clk), .reset_n(reset_n), .go(go), .sel(sel),
    .phase_first_rank(dut.phase_first_rank), .mem_phase_req(mreq), .mem_data(mdat));
  cmt_channel dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .apb_req(req),
    .pready(rdy), .prdata(prd), .pslverr(pslv), .mem_phase_req(mreq),
    .mem_phase_kind(cmt_pkg::CMT_PH_DATA), .phase_first_rank(), .phase_second_rank(),
    .mem_phase_done(done), .memory_timer_trigger(trig), .memory_timer_ready(),
    .group_a_taps(), .group_b_taps(), .buffer_read_request(rd), .buffer_write_request(wr),
    .buffer_timer_trigger(), .buffer_read_phase(rph), .buffer_write_phase(wph),
    .mem_data(mdat), .io_register(io), .start_io_instruction(st[0]),
    .halt_io_instruction(st[1]), .acknowledge_io_instruction(st[2]),
    .device_interrupt(st[3]), .count_load_strobe(st[4]), .byte_pointer_load_strobe(st[5]),
    .presence_strobe(st[6]), .count_step_strobe(st[7]), .respond_strobe(st[8]),
    .device_address(dva), .address_match(match), .start_refused(refd),
    .interrupt_pending(), .byte_count(cnt), .byte_pointer(bp), .byte_presence(pres),
    .response_word(resp));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Launch counter for the memory line
  always @(posedge sys_clk) begin
    if (trig && !trig_q) rises++;
    trig_q <= trig;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // One APB transfer; waits on pready, so any slave latency is accepted
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk) req <= '{1'b1, 1'b0, w, a, d, 4'hF};
    @(posedge sys_clk) req.penable <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (rdy === 1'b1) break;
    end
    q = pslv ? 32'hFFFFFFFF : prd;
    req <= '0;
  endtask
  // Pulse one strobe; results are read at the following falling edge
  task fire(input int i);
    @(posedge sys_clk) st[i] <= 1'b1;
    @(posedge sys_clk) st <= '0;
    @(negedge sys_clk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    summarize;
  end
  initial begin
    {reset_n, go, sel, rd, wr, st, io} = '0;
    req = '0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h00000C00, q);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'hFFFFFFFF, q);
    @(posedge sys_clk) go <= 1'b1;
    @(posedge sys_clk) go <= 1'b0;
    for (int n = 0; n < 200 && done !== 1'b1; n++) @(posedge sys_clk);
    chk("phase done", 32'h1, 32'(done));
    chk("launches", 32'h2, rises);
    $display("memory phase test done");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 12'h000, 32'(m));
      @(posedge sys_clk) {rd, wr} <= 2'b11;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("write wins", 32'(m), 32'(wph));
      chk("read wins", 32'(1 - m), 32'(rph));
      @(posedge sys_clk) {rd, wr} <= 2'b00;
      repeat (6) @(posedge sys_clk);
    end
    $display("buffer test done");
    @(posedge sys_clk) io <= 32'h5A000000;
    fire(0);
    chk("dev addr", 32'h5A, 32'(dva));
    fire(1);
    chk("match", 32'h1, 32'(match));
    @(posedge sys_clk) io <= 32'h33000000;
    fire(1);
    chk("no match", 32'h0, 32'(match));
    fire(3);
    fire(0);
    chk("refused", 32'h1, 32'(refd));
    chk("addr kept", 32'h5A, 32'(dva));
    @(posedge sys_clk) io <= 32'h5A000000;
    fire(2);
    @(posedge sys_clk) io <= 32'h33000000;
    fire(0);
    chk("new addr", 32'h33, 32'(dva));
    $display("address test done");
    apb(1'b1, 12'h000, 32'h0);
    fire(4);
    chk("count load", 32'h7, 32'(cnt));
    @(posedge sys_clk) sel <= 1'b1;
    fire(5);
    chk("ptr fwd", 32'h02006, 32'(bp));
    fire(6);
    chk("presence", 32'h3, 32'(pres));
    fire(7);
    chk("count step", 32'h5, 32'(cnt));
    chk("ptr up", 32'h02008, 32'(bp));
    fire(8);
    chk("response", 32'h5, resp);
    apb(1'b1, 12'h000, 32'h2);
    fire(5);
    chk("ptr rev", 32'h02005, 32'(bp));
    fire(6);
    fire(7);
    chk("ptr down", 32'h02002, 32'(bp));
    apb(1'b0, 12'h008, 32'h0);
    chk("count reg", 32'h2, q);
    $display("counter test done");
    summarize;
  end
endmodule
`default_nettype wire
